// ### logic/e1tpc_consts.svh
// constants for the tributary port control block
`ifndef E1TPC_CONSTS_SVH
`define E1TPC_CONSTS_SVH
`define E1TPC_NUM_CH 8
`define E1TPC_ES_W 16
`define E1TPC_FIFO_DEPTH 32
`define E1TPC_CLK_HZ 40000000
`define E1TPC_SEC_CYC (`E1TPC_CLK_HZ)
`define E1TPC_ES_MAX 16'hFFFF
`define E1TPC_LB_OFF 2'h0
`define E1TPC_LB_LOCAL 2'h1
`define E1TPC_LB_REMOTE 2'h2
`define E1TPC_LB_REQ 2'h3
`define E1TPC_CODE_ZS 1'b0
`define E1TPC_CODE_AMI 1'b1
`define E1TPC_RATE_E1 1'b0
`define E1TPC_RATE_T1 1'b1
`endif

// ### logic/e1tpc_fifo.sv
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module e1tpc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  e1tpc_stream_if.snk wr,
  e1tpc_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_reg;
  logic [AW-1:0] rptr_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;
  assign wr.ready = (cnt_reg != (AW+1)'(DEPTH));
  assign rd.valid = (cnt_reg != '0);
  assign rd.data = mem[rptr_reg];
  assign push = wr.valid && wr.ready;
  assign pop = rd.valid && rd.ready;
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wptr_reg] <= wr.data;
    end
  end
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wptr_reg <= (wptr_reg == AW'(DEPTH-1)) ? '0 : wptr_reg + 1'b1;
      end
      if (pop) begin
        rptr_reg <= (rptr_reg == AW'(DEPTH-1)) ? '0 : rptr_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ### logic/e1tpc_pkg.sv
// types for the tributary port control block
package e1tpc_pkg;
  typedef enum logic [2:0] {
    E1TPC_IDLE = 3'b001,
    E1TPC_APPLY = 3'b010,
    E1TPC_CLEAR = 3'b100
  } e1tpc_state_e;
  typedef logic [1:0] e1tpc_loop_t;
endpackage

// ### logic/e1tpc_stream_if.sv
// valid/ready stream carrier between block modules
`timescale 1ns/1ps
interface e1tpc_stream_if #(
  parameter int WIDTH = 8
);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ### logic/e1tpc_top.sv
// per-channel control, alarms and errored-seconds counting
`timescale 1ns/1ps
`include "e1tpc_consts.svh"
// Overview of operation
// - disabled channel sends nothing and raises no alarms
// - disabled channel drives its front panel indicator off
// - per-channel line code select to line interface: zero-substitution or AMI
// - auto alarm on loss sends alarm indication signal to remote side
// - loopback select: off, local, remote, request remote loopback
// - per-channel errored seconds counter counts while receive signal lost
// - channel clear flag plus apply clears that channel's counter
// - global clear zeroes all channel counters at once
// - report loss, detected alarm signal, transmit failure, errored seconds
// - one E1 or T1 rate select shared by all channels unless coax-only
module e1tpc_top
  import e1tpc_pkg::*;
#(
  parameter int NUM_CH = `E1TPC_NUM_CH,
  parameter int ES_W = `E1TPC_ES_W,
  parameter int SEC_CYC = `E1TPC_SEC_CYC,
  parameter bit COAX_ONLY = 1'b0
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic apply_in,
  input wire logic clear_all_in,
  input wire logic [NUM_CH-1:0] service_en_in,
  input wire logic [NUM_CH-1:0] line_code_in,
  input wire logic [NUM_CH-1:0] auto_alarm_on_loss_in,
  input wire logic [2*NUM_CH-1:0] loopback_in,
  input wire logic [NUM_CH-1:0] clear_perf_counter_in,
  input wire logic rate_t1_in,
  input wire logic [NUM_CH-1:0] receive_signal_loss_in,
  input wire logic [NUM_CH-1:0] alarm_indication_signal_in,
  input wire logic [NUM_CH-1:0] tx_fault_in,
  input wire logic es_ready_in,
  output logic [NUM_CH-1:0] tx_enable_out,
  output logic [NUM_CH-1:0] send_alarm_out,
  output logic [NUM_CH-1:0] line_code_out,
  output logic [2*NUM_CH-1:0] loopback_out,
  output logic rate_t1_out,
  output logic [NUM_CH-1:0] led_out,
  output logic [NUM_CH-1:0] loss_stat_out,
  output logic [NUM_CH-1:0] ais_stat_out,
  output logic [NUM_CH-1:0] tx_fail_stat_out,
  output logic [NUM_CH*ES_W-1:0] errored_seconds_out,
  output logic es_valid_out,
  output logic [ES_W+7:0] es_data_out,
  output logic apply_busy_out
);
  localparam int SW = $clog2(SEC_CYC + 1);
  localparam int FW = ES_W + 8;
  // ==========================================================
  // pin synchronisers
  logic [3*NUM_CH+2:0] s1_reg;
  logic [3*NUM_CH+2:0] s2_reg;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else begin
      s1_reg <= {apply_in, clear_all_in, es_ready_in, receive_signal_loss_in,
                 alarm_indication_signal_in, tx_fault_in};
      s2_reg <= s1_reg;
    end
  end
  logic apply_s;
  logic clear_all_s;
  logic es_rdy_s;
  logic apply_d_reg;
  logic clr_d_reg;
  logic [NUM_CH-1:0] los_s;
  logic [NUM_CH-1:0] ais_s;
  logic [NUM_CH-1:0] txf_s;
  assign {apply_s, clear_all_s, es_rdy_s, los_s, ais_s, txf_s} = s2_reg;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      apply_d_reg <= 1'b0;
      clr_d_reg <= 1'b0;
    end else begin
      apply_d_reg <= apply_s;
      clr_d_reg <= clear_all_s;
    end
  end
  wire apply_p = apply_s && !apply_d_reg;
  wire clr_all_p = clear_all_s && !clr_d_reg;
  // ==========================================================
  // apply sequencer
  e1tpc_state_e state_reg;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg <= E1TPC_IDLE;
    end else begin
      case (state_reg)
        E1TPC_IDLE: begin
          if (apply_p) begin
            state_reg <= E1TPC_APPLY;
          end
        end
        E1TPC_APPLY: begin
          state_reg <= E1TPC_CLEAR;
        end
        E1TPC_CLEAR: begin
          state_reg <= E1TPC_IDLE;
        end
        default: begin
          state_reg <= E1TPC_IDLE;
        end
      endcase
    end
  end
  wire latch_now = (state_reg == E1TPC_APPLY);
  wire clr_sel_now = (state_reg == E1TPC_CLEAR);
  // ==========================================================
  // latched configuration
  logic [NUM_CH-1:0] svc_reg;
  logic [NUM_CH-1:0] code_reg;
  logic [NUM_CH-1:0] auto_reg;
  logic [2*NUM_CH-1:0] loop_reg;
  logic [NUM_CH-1:0] clrsel_reg;
  logic rate_reg;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      svc_reg <= '0;
      code_reg <= '0;
      auto_reg <= '0;
      loop_reg <= '0;
      clrsel_reg <= '0;
      rate_reg <= `E1TPC_RATE_E1;
    end else if (latch_now) begin
      svc_reg <= service_en_in;
      code_reg <= line_code_in;
      auto_reg <= auto_alarm_on_loss_in;
      loop_reg <= loopback_in;
      clrsel_reg <= clear_perf_counter_in;
      rate_reg <= COAX_ONLY ? `E1TPC_RATE_E1 : rate_t1_in;
    end
  end
  // ==========================================================
  // one-second tick
  logic [SW-1:0] sec_cnt_reg;
  logic sec_tick;
  assign sec_tick = (sec_cnt_reg == SW'(SEC_CYC - 1));
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sec_cnt_reg <= '0;
    end else begin
      sec_cnt_reg <= sec_tick ? '0 : sec_cnt_reg + 1'b1;
    end
  end
  // ==========================================================
  // per-channel counters and outputs
  logic [NUM_CH-1:0] lossy_reg;
  logic [ES_W-1:0] es_reg [NUM_CH];
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          lossy_reg[g] <= 1'b0;
          es_reg[g] <= '0;
        end else begin
          if (clr_all_p) begin
            es_reg[g] <= '0;
          end else if (clr_sel_now && clrsel_reg[g]) begin
            es_reg[g] <= '0;
          end else if (sec_tick && (lossy_reg[g] || los_s[g]) &&
                       es_reg[g] != '1) begin
            es_reg[g] <= es_reg[g] + 1'b1;
          end
          if (sec_tick) begin
            lossy_reg[g] <= 1'b0;
          end else if (los_s[g]) begin
            lossy_reg[g] <= 1'b1;
          end
        end
      end
      always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          tx_enable_out[g] <= 1'b0;
          send_alarm_out[g] <= 1'b0;
          led_out[g] <= 1'b0;
          loss_stat_out[g] <= 1'b0;
          ais_stat_out[g] <= 1'b0;
          tx_fail_stat_out[g] <= 1'b0;
          errored_seconds_out[g*ES_W +: ES_W] <= '0;
        end else begin
          tx_enable_out[g] <= svc_reg[g];
          send_alarm_out[g] <= svc_reg[g] && auto_reg[g] && los_s[g];
          led_out[g] <= svc_reg[g];
          loss_stat_out[g] <= svc_reg[g] && los_s[g];
          ais_stat_out[g] <= svc_reg[g] && ais_s[g];
          tx_fail_stat_out[g] <= svc_reg[g] && txf_s[g];
          errored_seconds_out[g*ES_W +: ES_W] <= es_reg[g];
        end
      end
    end
  endgenerate
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      line_code_out <= '0;
      loopback_out <= '0;
      rate_t1_out <= 1'b0;
      apply_busy_out <= 1'b0;
    end else begin
      line_code_out <= code_reg;
      loopback_out <= loop_reg;
      rate_t1_out <= rate_reg;
      apply_busy_out <= (state_reg != E1TPC_IDLE);
    end
  end
  // ==========================================================
  // report stream: snapshot of each channel's count every second
  e1tpc_stream_if #(.WIDTH(FW)) in_s ();
  e1tpc_stream_if #(.WIDTH(FW)) out_s ();
  logic [7:0] rep_ch_reg;
  logic rep_act_reg;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rep_ch_reg <= '0;
      rep_act_reg <= 1'b0;
    end else if (sec_tick) begin
      rep_act_reg <= 1'b1;
      rep_ch_reg <= '0;
    end else if (rep_act_reg && in_s.ready) begin
      if (rep_ch_reg == 8'(NUM_CH - 1)) begin
        rep_act_reg <= 1'b0;
      end else begin
        rep_ch_reg <= rep_ch_reg + 8'h01;
      end
    end
  end
  assign in_s.valid = rep_act_reg;
  assign in_s.data = {rep_ch_reg, es_reg[rep_ch_reg[$clog2(NUM_CH)-1:0]]};
  e1tpc_fifo #(.WIDTH(FW), .DEPTH(`E1TPC_FIFO_DEPTH)) u_fifo (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .wr(in_s.snk),
    .rd(out_s.src)
  );
  // output stage register with skid-free handshake
  assign out_s.ready = !es_valid_out || es_rdy_s;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      es_valid_out <= 1'b0;
      es_data_out <= '0;
    end else if (out_s.ready) begin
      es_valid_out <= out_s.valid;
      es_data_out <= out_s.data;
    end
  end
endmodule

// ### verif/e1tpc_line_model.sv
// far-side line equipment: report sink that can stall
`timescale 1ns/1ps
module e1tpc_line_model #(
  parameter int ES_W = 16
) (
  input wire logic clk_in,
  input wire logic stall_in,
  input wire logic es_valid_in,
  input wire logic [ES_W+7:0] es_data_in,
  output logic es_ready_out,
  output int words_out
);
  // the block reads ready through two flops, so a word leaves its
  // output stage when ready stood three edges earlier
  logic rdy_d1_reg;
  logic rdy_d2_reg;
  initial begin
    es_ready_out = 1'b0;
    rdy_d1_reg = 1'b0;
    rdy_d2_reg = 1'b0;
    words_out = 0;
  end
  always @(posedge clk_in) begin
    es_ready_out <= !stall_in;
    rdy_d1_reg <= es_ready_out;
    rdy_d2_reg <= rdy_d1_reg;
    if (es_valid_in && rdy_d2_reg) begin
      words_out <= words_out + 1;
    end
  end
endmodule

// ### verif/e1tpc_properties.sv
// port assertions for the tributary port control block
`timescale 1ns/1ps
module e1tpc_properties #(
  parameter int NUM_CH = 8,
  parameter int ES_W = 16
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic apply_in,
  input wire logic clear_all_in,
  input wire logic [NUM_CH-1:0] receive_signal_loss_in,
  input wire logic [NUM_CH-1:0] tx_enable_out,
  input wire logic [NUM_CH-1:0] send_alarm_out,
  input wire logic [NUM_CH-1:0] line_code_out,
  input wire logic [2*NUM_CH-1:0] loopback_out,
  input wire logic rate_t1_out,
  input wire logic [NUM_CH-1:0] led_out,
  input wire logic [NUM_CH-1:0] loss_stat_out,
  input wire logic [NUM_CH-1:0] ais_stat_out,
  input wire logic [NUM_CH-1:0] tx_fail_stat_out,
  input wire logic [NUM_CH*ES_W-1:0] errored_seconds_out,
  input wire logic es_valid_out,
  input wire logic [ES_W+7:0] es_data_out,
  input wire logic apply_busy_out
);
  logic [ES_W-1:0] es0;
  assign es0 = errored_seconds_out[ES_W-1:0];
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // ==========
  // relations
  led_off_a: assert property ((led_out & ~tx_enable_out) == '0)
    else $error("led lit on disabled channel");
  alarm_gate_a: assert property (((send_alarm_out | loss_stat_out |
    ais_stat_out | tx_fail_stat_out) & ~tx_enable_out) == '0)
    else $error("alarm on disabled channel");
  loss_lag_a: assert property (tx_enable_out == $past(tx_enable_out, 4)
    |-> loss_stat_out == ($past(receive_signal_loss_in, 3) & tx_enable_out))
    else $error("loss status wrong");
  es_step_a: assert property (es0 != $past(es0)
    |-> es0 == $past(es0) + 1'b1 || es0 == '0)
    else $error("counter jumped");
  clear_all_a: assert property ($rose(clear_all_in)
    |-> ##[3:6] errored_seconds_out == '0)
    else $error("global clear missed");
  busy_start_a: assert property ($rose(apply_in) && !apply_busy_out
    |-> ##[3:4] apply_busy_out)
    else $error("apply not taken");
  busy_len_a: assert property ($rose(apply_busy_out)
    |-> apply_busy_out[*2] ##1 !apply_busy_out)
    else $error("busy length wrong");
  cfg_hold_a: assert property (!apply_busy_out && !$past(apply_busy_out)
    |-> $stable({line_code_out, loopback_out, rate_t1_out, tx_enable_out}))
    else $error("config moved without apply");
  report_ch_a: assert property (es_valid_out
    |-> es_data_out[ES_W+7:ES_W] < NUM_CH)
    else $error("bad report channel");
endmodule

// ### verif/e1tpc_tb_top.sv
// testbench for the tributary port control block
`timescale 1ns/1ps
module e1tpc_tb_top;
  localparam int EW = 4;
  localparam int SC = 100;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic apply = 1'b0, clr = 1'b0, rate = 1'b0, stall = 1'b0;
  logic [7:0] svc = '0, code = '0, auto = '0, pclr = '0;
  logic [7:0] receive_signal_loss = '0, alarm_indication_signal = '0, flt = '0;
  logic [15:0] lb = '0;
  logic [7:0] tx_en, alarm, code_o, led, los_o, ais_o, flt_o;
  logic [15:0] lb_o;
  logic rate_o, es_v, busy, rdy;
  logic [8*EW-1:0] es;
  logic [EW+7:0] es_d;
  int words, w0, i, fails = 0, total_checks = 0;
  always #12.5 clk_in = ~clk_in;
  e1tpc_top #(.ES_W(EW), .SEC_CYC(SC)) dut_u (
    .clk_in(clk_in), .rstn_in(rstn_in), .apply_in(apply),
    .clear_all_in(clr), .service_en_in(svc), .line_code_in(code),
    .auto_alarm_on_loss_in(auto), .loopback_in(lb),
    .clear_perf_counter_in(pclr), .rate_t1_in(rate),
    .receive_signal_loss_in(receive_signal_loss), .alarm_indication_signal_in(alarm_indication_signal),
    .tx_fault_in(flt), .es_ready_in(rdy), .tx_enable_out(tx_en),
    .send_alarm_out(alarm), .line_code_out(code_o), .loopback_out(lb_o),
    .rate_t1_out(rate_o), .led_out(led), .loss_stat_out(los_o),
    .ais_stat_out(ais_o), .tx_fail_stat_out(flt_o),
    .errored_seconds_out(es), .es_valid_out(es_v), .es_data_out(es_d),
    .apply_busy_out(busy));
  e1tpc_line_model #(.ES_W(EW)) line_u (.clk_in(clk_in),
    .stall_in(stall), .es_valid_in(es_v), .es_data_in(es_d),
    .es_ready_out(rdy), .words_out(words));
  // ==========
  // tasks
  task automatic chk(input string n, input logic [31:0] e, g);
    total_checks++;
    if (e !== g) begin
      fails++;
      $display("[ERR] %s exp %0h got %0h", n, e, g);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic do_apply();
    int k;
    apply = 1'b1;
    for (k = 0; k < 10 && busy !== 1'b1; k++) cyc(1);
    if (k == 10) begin
      chk("busy", 1, 0);
      stop_test();
    end
    apply = 1'b0;
    cyc(6);
  endtask
  // ==========
  // sequence
  initial begin
    cyc(2);
    rstn_in = 1'b1;
    cyc(1);
    chk("rst tx", 0, tx_en);
    chk("rst es", 0, es);
    svc = 8'h7F; code = 8'hA5; auto = 8'hFD; lb = 16'hE4E4; rate = 1'b1;
    do_apply();
    chk("tx", 8'h7F, tx_en);
    chk("code", 8'hA5, code_o);
    chk("loop", 16'hE4E4, lb_o);
    chk("rate", 1, rate_o);
    chk("led7", 0, led[7]);
    code = 8'h00; rate = 1'b0;
    receive_signal_loss = 8'h83; alarm_indication_signal = 8'h84; flt = 8'h88;
    cyc(SC * 3 + 50);
    chk("code held", 8'hA5, code_o);
    chk("los", 8'h03, los_o);
    chk("ais", 8'h04, ais_o);
    chk("flt", 8'h08, flt_o);
    chk("alarm", 8'h01, alarm);
    chk("es0", 1, es[EW-1:0] inside {3, 4});
    chk("es2", 0, es[3*EW-1:2*EW]);
    cyc(SC * 14);
    chk("es sat", 4'hF, es[EW-1:0]);
    w0 = words;
    stall = 1'b1;
    cyc(SC * 6);
    chk("full", 1, es_v);
    stall = 1'b0;
    for (i = 0; i < 300 && es_v === 1'b1; i++) cyc(1);
    chk("drained", 1, i < 300 && words - w0 >= 32);
    receive_signal_loss = 8'h00;
    cyc(SC + 50);
    pclr = 8'h01;
    do_apply();
    chk("es0 clr", 0, es[EW-1:0]);
    chk("es1 kept", 4'hF, es[2*EW-1:EW]);
    pclr = 8'h00;
    clr = 1'b1;
    cyc(4);
    clr = 1'b0;
    cyc(4);
    chk("clr all", 0, es);
    stop_test();
  end
endmodule
bind e1tpc_top e1tpc_properties #(.NUM_CH(NUM_CH), .ES_W(ES_W)) chk_u (.*);
